//--- bsme_core.sv
// Purpose: executes branch-if-irq-disabled, io bit set/clear, shifts, flag ops,
//          bit transfer through T, register moves and pointer loads
// Assumes: commands arrive decoded; data memory answers combinationally
// Notes:   one command in flight; two-cycle commands drop o_ready for one cycle

`timescale 1ns/1ns

module bsme_core (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire bsme_pkg::bsme_cmd_type i_cmd,
  input  wire bsme_pkg::bsme_sw_type  i_sw,
  input  wire logic [7:0]             i_dmem_rdata,
  output logic                        o_ready,
  output logic                        o_done,
  output logic [15:0]                 o_pc,
  output logic [7:0]                  o_flags,
  output logic [15:0]                 o_dmem_addr,
  output logic                        o_dmem_rd,
  output logic [7:0]                  o_sw_rdata
);
  import bsme_pkg::*;

  // ****************************************
  // state and command holding
  // ****************************************
  bsme_state_type state_ff;
  bsme_state_type nxt_state;
  bsme_cmd_type   cmd_ff;
  logic           ready_ff;
  logic           done_ff;
  logic [15:0]    pc_ff;
  logic [15:0]    nxt_pc;
  logic [7:0]     flags_ff;
  logic [7:0]     nxt_flags;
  logic [15:0]    daddr_ff;
  logic           drd_ff;
  logic [7:0]     rdata_ff;
  logic [7:0]     io_ff [32];

  wire          first  = i_cmd.valid & ready_ff;
  wire          second = (state_ff == ST_SECOND);
  bsme_cmd_type cur;
  assign cur = second ? cmd_ff : i_cmd;

  wire is_branch_if_irq_disabled  = (cur.op == OP_BRANCH_IF_IRQ_DISABLED);
  wire is_ioset = (cur.op == OP_IOSET);
  wire is_ioclr = (cur.op == OP_IOCLR);
  wire is_swap  = (cur.op == OP_SWAP);
  wire is_fset  = (cur.op == OP_FSET);
  wire is_fclr  = (cur.op == OP_FCLR);
  wire is_bst   = (cur.op == OP_BST);
  wire is_bld   = (cur.op == OP_BLD);
  wire is_mov   = (cur.op == OP_MOV);
  wire is_reg_pair_copy  = (cur.op == OP_REG_PAIR_COPY);
  wire is_ldi   = (cur.op == OP_LDI);
  wire is_ld    = (cur.op == OP_LD);
  wire is_shift = (cur.op >= OP_LSL) & (cur.op <= OP_ASR);

  // taken only while interrupts are disabled
  wire br_taken = ~flags_ff[FLAG_I];
  wire two_cyc  = is_ioset | is_ioclr | is_ld | (is_branch_if_irq_disabled & br_taken);

  // ****************************************
  // register file and operands
  // ****************************************
  logic [4:0][4:0] raddr;
  logic [4:0][7:0] rdat;
  wire  [4:0]      ptr_lo_idx = cur.ptr_y ? PTR_Y_LO : PTR_X_LO;

  assign raddr[0] = cur.dst;
  // a pair copy reads the even register of the source pair
  assign raddr[1] = is_reg_pair_copy ? {cur.src[4:1], 1'b0} : cur.src;
  assign raddr[2] = ptr_lo_idx;
  assign raddr[3] = is_reg_pair_copy ? {cur.src[4:1], 1'b1} : {ptr_lo_idx[4:1], 1'b1};
  assign raddr[4] = i_sw.addr[4:0];

  wire [7:0]  rv_d    = rdat[0];
  wire [7:0]  rv_s    = rdat[1];
  wire [15:0] ptr     = {rdat[3], rdat[2]};
  wire [15:0] ptr_dec = ptr - 16'h0001;
  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [7:0]  bmask   = 8'h01 << cur.bsel;

  // ****************************************
  // shifter
  // ****************************************
  logic [7:0] sh_res;
  logic       sh_c;
  logic       sh_v;
  logic       sh_n;
  logic       sh_z;

  bsme_shift_unit u_shift (
    .i_op    (cur.op),
    .i_val   (rv_d),
    .i_carry (flags_ff[FLAG_C]),
    .o_res   (sh_res),
    .o_c     (sh_c),
    .o_v     (sh_v),
    .o_n     (sh_n),
    .o_z     (sh_z)
  );

  // ****************************************
  // register write selection
  // ****************************************
  // only the selected bit takes T
  wire [7:0] bld_val = (rv_d & ~bmask) | (flags_ff[FLAG_T] ? bmask : 8'h00);
  wire [7:0] swap_val = {rv_d[3:0], rv_d[7:4]};

  wire [7:0] byte_res = is_shift ? sh_res   :
                        is_swap  ? swap_val :
                        is_bld   ? bld_val  :
                        is_mov   ? rv_s     :
                        is_ldi   ? cur.imm  : i_dmem_rdata;

  // pointer moves in the first cycle, data lands in the second
  wire ptr_upd   = first & is_ld & (cur.pmode != PM_PLAIN);
  wire [15:0] ptr_new = (cur.pmode == PM_PREDEC) ? ptr_dec : ptr_inc;
  wire byte_we   = first & (is_shift | is_swap | is_bld | is_mov | is_ldi);
  wire ins_we    = byte_we | (first & is_reg_pair_copy) | ptr_upd | (second & is_ld);
  wire ins_pair  = (first & is_reg_pair_copy) | ptr_upd;
  wire [4:0]  ins_waddr = ptr_upd ? ptr_lo_idx : cur.dst;
  wire [15:0] ins_wdata = ptr_upd ? ptr_new :
                          is_reg_pair_copy ? {rdat[3], rv_s} : {8'h00, byte_res};

  // software writes yield to an instruction writing in the same cycle
  wire sw_gpr_wr = i_sw.wr & (i_sw.addr < SW_IO_BASE);
  wire rf_we     = ins_we | sw_gpr_wr;

  bsme_regfile u_regs (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_raddr (raddr),
    .o_rdata (rdat),
    .i_we    (rf_we),
    .i_pair  (ins_we & ins_pair),
    .i_waddr (ins_we ? ins_waddr : i_sw.addr[4:0]),
    .i_wdata (ins_we ? ins_wdata : {8'h00, i_sw.wdata})
  );

  // ****************************************
  // io registers
  // ****************************************
  // read-modify-write in the second cycle
  wire       io_ins = second & (is_ioset | is_ioclr);
  wire [7:0] io_cur = io_ff[cur.src];
  wire [7:0] io_bit = is_ioset ? (io_cur | bmask) : (io_cur & ~bmask);
  wire       sw_io  = i_sw.wr & (i_sw.addr >= SW_IO_BASE) & (i_sw.addr < SW_FLAGS);
  wire       io_we  = io_ins | sw_io;
  wire [4:0] io_wa  = io_ins ? cur.src : i_sw.addr[4:0];
  wire [7:0] io_wd  = io_ins ? io_bit : i_sw.wdata;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_io
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          io_ff[g] <= IO_RST;
        end else if (io_we & (io_wa == 5'(g))) begin
          io_ff[g] <= io_wd;
        end
      end
    end
  endgenerate

  // ****************************************
  // flags
  // ****************************************
  // Z C N V from the shifter, S and above kept
  wire [7:0] sh_flags = {flags_ff[7:4], sh_v, sh_n, sh_z, sh_c};
  wire [7:0] set_flags = flags_ff | bmask;
  wire [7:0] clr_flags = flags_ff & ~bmask;
  // T alone takes the source bit
  wire [7:0] bst_flags = {flags_ff[7], |(rv_s & bmask), flags_ff[5:0]};
  wire       ins_flags = first & (is_shift | is_fset | is_fclr | is_bst);
  wire       sw_flags  = i_sw.wr & (i_sw.addr == SW_FLAGS);

  assign nxt_flags = ~ins_flags ? (sw_flags ? i_sw.wdata : flags_ff) :
                     is_shift   ? sh_flags  :
                     is_fset    ? set_flags :
                     is_fclr    ? clr_flags : bst_flags;

  // ****************************************
  // program counter and sequencing
  // ****************************************
  // target is pc plus signed offset plus one
  wire [15:0] br_target = pc_ff + {{9{cur.imm[6]}}, cur.imm[6:0]} + 16'h0001;
  wire        pc_adv    = (first & ~two_cyc) | second;
  wire        sw_pc_lo  = i_sw.wr & (i_sw.addr == SW_PC_LO);
  wire        sw_pc_hi  = i_sw.wr & (i_sw.addr == SW_PC_HI);

  assign nxt_pc = pc_adv   ? ((second & is_branch_if_irq_disabled) ? br_target : pc_ff + 16'h0001) :
                  sw_pc_lo ? {pc_ff[15:8], i_sw.wdata} :
                  sw_pc_hi ? {i_sw.wdata, pc_ff[7:0]} : pc_ff;

  // both codes are legal, so the case needs no default item
  always_comb begin
    nxt_state = ST_FIRST;
    unique case (state_ff)
      ST_FIRST: begin
        nxt_state = (first & two_cyc) ? ST_SECOND : ST_FIRST;
      end
      ST_SECOND: begin
        nxt_state = ST_FIRST;
      end
    endcase
  end

  // address of the load, lowered pointer for pre-decrement
  wire [15:0] ld_addr = (cur.pmode == PM_PREDEC) ? ptr_dec : ptr;

  // ****************************************
  // software read
  // ****************************************
  wire [7:0] sw_rsel = (i_sw.addr < SW_IO_BASE) ? rdat[4]             :
                       (i_sw.addr < SW_FLAGS)   ? io_ff[i_sw.addr[4:0]] :
                       (i_sw.addr == SW_FLAGS)  ? flags_ff            :
                       (i_sw.addr == SW_PC_LO)  ? pc_ff[7:0]          :
                       (i_sw.addr == SW_PC_HI)  ? pc_ff[15:8]         : 8'h00;

  // ****************************************
  // registers
  // ****************************************
  // sequencing; ready drops for exactly one cycle after a two-cycle take
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_FIRST;
      ready_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= ~(first & two_cyc);
      done_ff  <= pc_adv;
    end
  end

  // architectural state: program counter and core flag register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_ff    <= PC_RST;
      flags_ff <= FLAGS_RST;
    end else begin
      pc_ff    <= nxt_pc;
      flags_ff <= nxt_flags;
    end
  end

  // command held so the second cycle does not depend on the port
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_ff <= '0;
    end else if (first) begin
      cmd_ff <= i_cmd;
    end
  end

  // data memory request; the address holds until the next load
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      daddr_ff <= 16'h0000;
      drd_ff   <= 1'b0;
    end else begin
      drd_ff <= first & is_ld;
      if (first & is_ld) begin
        daddr_ff <= ld_addr;
      end
    end
  end

  // read data stands one cycle and is zero otherwise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= i_sw.rd ? sw_rsel : 8'h00;
    end
  end

  assign o_ready     = ready_ff;
  assign o_done      = done_ff;
  assign o_pc        = pc_ff;
  assign o_flags     = flags_ff;
  assign o_dmem_addr = daddr_ff;
  assign o_dmem_rd   = drd_ff;
  assign o_sw_rdata  = rdata_ff;

endmodule : bsme_core

//--- bsme_core_monitor.sv
// Purpose: port-level timing and flag checks for bsme_core
// Assumes: one clock domain, synchronous active-high reset
// Notes:   flags and pc are judged only at the command port edges

`timescale 1ns/1ns

module bsme_core_monitor (
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire bsme_pkg::bsme_cmd_type i_cmd,
  input wire logic                   o_ready,
  input wire logic                   o_done,
  input wire logic [15:0]            o_pc,
  input wire logic [7:0]             o_flags,
  input wire logic                   o_dmem_rd
);
  import bsme_pkg::*;

  // ****************************************
  // command classification
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  wire        take = i_cmd.valid && o_ready;
  wire        brt  = i_cmd.op == OP_BRANCH_IF_IRQ_DISABLED && !o_flags[FLAG_I];
  wire        two  = i_cmd.op inside {OP_IOSET, OP_IOCLR, OP_LD} || brt;
  wire        shf  = i_cmd.op inside {OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR};
  wire        keep = i_cmd.op inside {OP_SWAP, OP_BLD, OP_MOV, OP_REG_PAIR_COPY, OP_LDI};
  wire [15:0] ofs  = {{9{i_cmd.imm[6]}}, i_cmd.imm[6:0]};

  // ****************************************
  // assertions
  // ****************************************
  AST_TWO_CYCLE: assert property (
    take && two |=> !o_ready && !o_done ##1 o_ready && o_done)
    else $error("two-cycle command timing wrong");
  AST_ONE_CYCLE: assert property (take && !two |=> o_ready && o_done)
    else $error("one-cycle command timing wrong");
  AST_BRANCH_TAKEN: assert property (
    take && brt |-> ##2 o_pc == $past(o_pc, 2) + $past(ofs, 2) + 16'h0001)
    else $error("branch target wrong");
  AST_BRANCH_FALL: assert property (
    take && i_cmd.op == OP_BRANCH_IF_IRQ_DISABLED && o_flags[FLAG_I] |=> o_pc == $past(o_pc) + 16'h0001)
    else $error("branch fall-through wrong");
  AST_TWO_NOFLAG: assert property (
    take && i_cmd.op inside {OP_IOSET, OP_IOCLR, OP_LD} |-> ##2 o_flags == $past(o_flags, 2))
    else $error("io or load changed flags");
  AST_FLAG_SET: assert property (
    take && i_cmd.op == OP_FSET |=> o_flags == ($past(o_flags) | (8'h01 << $past(i_cmd.bsel))))
    else $error("flag set wrong");
  AST_FLAG_CLR: assert property (
    take && i_cmd.op == OP_FCLR |=> o_flags == ($past(o_flags) & ~(8'h01 << $past(i_cmd.bsel))))
    else $error("flag clear wrong");
  AST_KEEP_FLAGS: assert property (take && keep |=> $stable(o_flags))
    else $error("flagless command changed flags");
  AST_BST_ONLY_T: assert property (
    take && i_cmd.op == OP_BST |=> (o_flags & 8'hbf) == ($past(o_flags) & 8'hbf))
    else $error("bit store touched other flags");
  AST_SHIFT_FLAGS: assert property (
    take && shf |=> o_flags[FLAG_V] == (o_flags[FLAG_N] ^ o_flags[FLAG_C]) &&
    o_flags[7:4] == $past(o_flags[7:4]))
    else $error("shift flags wrong");
  AST_LOAD_STROBE: assert property (take && i_cmd.op == OP_LD |=> o_dmem_rd ##1 !o_dmem_rd)
    else $error("load strobe wrong");
endmodule : bsme_core_monitor

bind bsme_core bsme_core_monitor u_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd),
  .o_ready(o_ready), .o_done(o_done), .o_pc(o_pc), .o_flags(o_flags), .o_dmem_rd(o_dmem_rd));

//--- bsme_core_test.sv
// Purpose: self-checking bench for bsme_core
// Assumes: data memory byte is derived from its address
// Notes:   register results are read back over the software port

`timescale 1ns/1ns

module bsme_core_test;
  import bsme_pkg::*;

  logic         i_clk, i_rst, o_ready, o_done, o_dmem_rd, rd_d;
  bsme_cmd_type i_cmd;
  bsme_sw_type  i_sw;
  logic [7:0]   o_flags, o_sw_rdata, fl;
  logic [7:0]   gpr [32];
  logic [7:0]   io  [32];
  logic [15:0]  o_pc, o_dmem_addr, pc;
  logic [7:0]   rq [$];
  logic [23:0]  dq [$];
  int           error_cnt, checked, i;
  wire  [7:0]   mem = o_dmem_addr[7:0] ^ o_dmem_addr[15:8] ^ 8'h5a;

  bsme_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd), .i_sw(i_sw), .i_dmem_rdata(mem),
    .o_ready(o_ready), .o_done(o_done), .o_pc(o_pc), .o_flags(o_flags),
    .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd), .o_sw_rdata(o_sw_rdata));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ****************************************
  // result watching
  // ****************************************
  task automatic judge(input logic [23:0] e, input logic [23:0] a);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : judge

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] a);
    judge({16'h0000, e}, {16'h0000, a});
  endtask : cmp_rd

  task automatic cmp_done(input logic [23:0] e, input logic [23:0] a);
    judge(e, a);
  endtask : cmp_done

  always @(posedge i_clk) rd_d <= i_sw.rd;

  always @(negedge i_clk) begin
    if (rd_d) cmp_rd(rq.pop_front(), o_sw_rdata);
    if (o_done === 1'b1 && !i_rst) begin
      cmp_done(dq.size() ? dq.pop_front() : 24'hx, {o_pc, o_flags});
    end
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // drivers and reference model
  // ****************************************
  task automatic sw(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sw <= '{w, !w, a, d};
    if (!w) rq.push_back(d);
    if (w && a < 7'h20) gpr[a[4:0]] = d;
    else if (w && a < 7'h40) io[a[4:0]] = d;
    else if (w && a == SW_FLAGS) fl = d;
    else if (w && a == SW_PC_LO) pc[7:0] = d;
    else if (w && a == SW_PC_HI) pc[15:8] = d;
    @(posedge i_clk);
    i_sw <= '0;
  endtask : sw

  task automatic run(input bsme_op_type op, input logic [4:0] d, input logic [4:0] s,
                     input logic [2:0] b, input logic [7:0] k, input logic py,
                     input bsme_pmode_type pm);
    logic [7:0]  v, r;
    logic [15:0] p;
    logic [4:0]  pb, dd;
    int          n;
    v = gpr[d];
    r = v;
    dd = d;
    pb = py ? PTR_Y_LO : PTR_X_LO;
    p = {gpr[pb + 5'h1], gpr[pb]};
    case (op)
      OP_LSL:  begin r = {v[6:0], 1'b0}; fl[FLAG_C] = v[7]; end
      OP_LSR:  begin r = {1'b0, v[7:1]}; fl[FLAG_C] = v[0]; end
      OP_ROL:  begin r = {v[6:0], fl[FLAG_C]}; fl[FLAG_C] = v[7]; end
      OP_ROR:  begin r = {fl[FLAG_C], v[7:1]}; fl[FLAG_C] = v[0]; end
      OP_ASR:  begin r = {v[7], v[7:1]}; fl[FLAG_C] = v[0]; end
      OP_SWAP: r = {v[3:0], v[7:4]};
      OP_FSET: fl[b] = 1'b1;
      OP_FCLR: fl[b] = 1'b0;
      OP_BST:  fl[FLAG_T] = gpr[s][b];
      OP_BLD:  r[b] = fl[FLAG_T];
      OP_MOV:  r = gpr[s];
      OP_REG_PAIR_COPY: begin gpr[d | 5'h1] = gpr[s | 5'h1]; r = gpr[s & 5'h1e]; dd = d & 5'h1e; end
      OP_LDI:  r = k;
      OP_IOSET: io[s][b] = 1'b1;
      OP_IOCLR: io[s][b] = 1'b0;
      OP_LD: begin
        if (pm == PM_PREDEC) p = p - 16'h1;
        r = p[7:0] ^ p[15:8] ^ 8'h5a;
        if (pm == PM_POSTINC) p = p + 16'h1;
        if (pm != PM_PLAIN) {gpr[pb + 5'h1], gpr[pb]} = p;
      end
      OP_BRANCH_IF_IRQ_DISABLED: if (!fl[FLAG_I]) pc = pc + {{9{k[6]}}, k[6:0]};
      default: r = v;
    endcase
    if (op inside {OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR}) begin
      fl[FLAG_Z] = (r == 8'h00);
      fl[FLAG_N] = r[7];
      fl[FLAG_V] = r[7] ^ fl[FLAG_C];
    end
    gpr[dd] = r;
    pc = pc + 16'h1;
    dq.push_back({pc, fl});
    @(posedge i_clk);
    i_cmd <= '{1'b1, op, d, s, b, k, py, pm};
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_ready !== 1'b1 && n < 9);
    i_cmd <= '0;
    do begin @(posedge i_clk); n++; end while (o_done !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
    sw(1'b0, {2'b00, d}, gpr[d]);
    sw(1'b0, {2'b00, d ^ 5'h1}, gpr[d ^ 5'h1]);
    sw(1'b0, {2'b01, s}, io[s]);
    for (n = 26; n < 30; n++) sw(1'b0, 7'(n), gpr[n]);
  endtask : run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_rst = 1'b1;
    i_cmd = '0;
    i_sw = '0;
    rd_d = 1'b0;
    error_cnt = 0;
    checked = 0;
    fl = FLAGS_RST;
    pc = PC_RST;
    foreach (gpr[j]) begin
      gpr[j] = GPR_RST;
      io[j] = IO_RST;
    end
    void'($urandom(94));
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    sw(1'b0, SW_FLAGS, FLAGS_RST);
    sw(1'b0, SW_PC_HI, 8'h00);
    sw(1'b1, SW_FLAGS, 8'($urandom));
    sw(1'b1, SW_PC_LO, 8'($urandom));
    sw(1'b1, SW_PC_HI, 8'($urandom));
    sw(1'b0, SW_FLAGS, fl);
    sw(1'b0, SW_PC_HI, pc[15:8]);
    sw(1'b1, 7'h50, 8'hff);
    sw(1'b0, 7'h50, 8'h00);
    for (i = 0; i < 8; i++) begin
      run(OP_FSET, 5'h0, 5'h0, 3'(i), 8'h00, 1'b0, PM_PLAIN);
      run(OP_FCLR, 5'h0, 5'h0, 3'(i), 8'h00, 1'b0, PM_PLAIN);
    end
    run(OP_BRANCH_IF_IRQ_DISABLED, 5'h0, 5'h0, 3'h0, 8'h7f, 1'b0, PM_PLAIN);
    sw(1'b1, 7'h1a, 8'hff);
    sw(1'b1, 7'h1b, 8'h00);
    run(OP_LD, 5'h3, 5'h0, 3'h0, 8'h00, 1'b0, PM_POSTINC);
    run(OP_LD, 5'h4, 5'h0, 3'h0, 8'h00, 1'b1, PM_PREDEC);
    for (i = 0; i < 200; i++) begin
      if (i % 8 == 0) sw(1'b1, 7'h20 | 7'($urandom_range(31)), 8'($urandom));
      run(bsme_op_type'($urandom_range(16)), 5'($urandom), 5'($urandom), 3'($urandom),
          8'($urandom), 1'($urandom),
          bsme_pmode_type'($urandom_range(2)));
    end
    sw(1'b0, SW_PC_LO, pc[7:0]);
    sw(1'b0, SW_FLAGS, fl);
    repeat (2) @(posedge i_clk);
    tally_and_finish();
  end
endmodule : bsme_core_test

//--- bsme_pkg.sv
// Purpose: shared types and constants for the bit, shift and move execution unit
// Assumes: 8-bit core, 32 working registers, 32 bit-addressable io registers
// Notes:   flag positions follow the core flag register layout I T H S V N Z C

package bsme_pkg;

  // ****************************************
  // core flag register bit positions
  // ****************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ****************************************
  // reset values and pointer registers
  // ****************************************
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  GPR_RST   = 8'h00;
  localparam logic [7:0]  IO_RST    = 8'h00;
  localparam logic [4:0]  PTR_X_LO  = 5'h1a;
  localparam logic [4:0]  PTR_Y_LO  = 5'h1c;

  // ****************************************
  // software port map
  // ****************************************
  localparam logic [6:0] SW_GPR_BASE = 7'h00;
  localparam logic [6:0] SW_IO_BASE  = 7'h20;
  localparam logic [6:0] SW_FLAGS    = 7'h40;
  localparam logic [6:0] SW_PC_LO    = 7'h41;
  localparam logic [6:0] SW_PC_HI    = 7'h42;

  typedef enum logic [4:0] {
    OP_BRANCH_IF_IRQ_DISABLED  = 5'h00,
    OP_IOSET = 5'h01,
    OP_IOCLR = 5'h02,
    OP_LSL   = 5'h03,
    OP_LSR   = 5'h04,
    OP_ROL   = 5'h05,
    OP_ROR   = 5'h06,
    OP_ASR   = 5'h07,
    OP_SWAP  = 5'h08,
    OP_FSET  = 5'h09,
    OP_FCLR  = 5'h0a,
    OP_BST   = 5'h0b,
    OP_BLD   = 5'h0c,
    OP_MOV   = 5'h0d,
    OP_REG_PAIR_COPY  = 5'h0e,
    OP_LDI   = 5'h0f,
    OP_LD    = 5'h10
  } bsme_op_type;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'h0,
    PM_POSTINC = 2'h1,
    PM_PREDEC  = 2'h2
  } bsme_pmode_type;

  typedef enum logic [0:0] {
    ST_FIRST  = 1'h0,
    ST_SECOND = 1'h1
  } bsme_state_type;

  typedef struct packed {
    logic           valid;
    bsme_op_type    op;
    logic [4:0]     dst;
    logic [4:0]     src;
    logic [2:0]     bsel;
    logic [7:0]     imm;
    logic           ptr_y;
    bsme_pmode_type pmode;
  } bsme_cmd_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bsme_sw_type;

endpackage : bsme_pkg

//--- bsme_regfile.sv
// Purpose: 32 x 8 working register file with five read ports and one write port
// Assumes: a pair write always lands on an even/odd register pair
// Notes:   reads are asynchronous so an instruction sees its operands in one cycle

`timescale 1ns/1ns

module bsme_regfile (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic [4:0][4:0] i_raddr,
  output logic      [4:0][7:0] o_rdata,
  input  wire logic            i_we,
  input  wire logic            i_pair,
  input  wire logic [4:0]      i_waddr,
  input  wire logic [15:0]     i_wdata
);
  import bsme_pkg::*;

  logic [7:0] regs_ff [32];

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_reg
      localparam logic [4:0] IDX = 5'(g);
      wire lo_hit = i_we & (i_pair ? (i_waddr[4:1] == IDX[4:1]) & ~IDX[0]
                                   : (i_waddr == IDX));
      wire hi_hit = i_we & i_pair & (i_waddr[4:1] == IDX[4:1]) & IDX[0];
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          regs_ff[g] <= GPR_RST;
        end else if (lo_hit) begin
          regs_ff[g] <= i_wdata[7:0];
        end else if (hi_hit) begin
          regs_ff[g] <= i_wdata[15:8];
        end
      end
    end
    for (g = 0; g < 5; g++) begin : g_rd
      assign o_rdata[g] = regs_ff[i_raddr[g]];
    end
  endgenerate

endmodule : bsme_regfile

//--- bsme_shift_unit.sv
// Purpose: combinational shift, rotate and arithmetic shift with flag results
// Assumes: op is one of the five shift operations when the result is used
// Notes:   sign flag is left to the caller; only Z C N V come out of here

`timescale 1ns/1ns

module bsme_shift_unit (
  input  wire bsme_pkg::bsme_op_type i_op,
  input  wire logic [7:0]            i_val,
  input  wire logic                  i_carry,
  output logic [7:0]                 o_res,
  output logic                       o_c,
  output logic                       o_v,
  output logic                       o_n,
  output logic                       o_z
);
  import bsme_pkg::*;

  wire left_sel = (i_op == OP_LSL) | (i_op == OP_ROL);

  wire [7:0] lsl_res = {i_val[6:0], 1'b0};
  wire [7:0] lsr_res = {1'b0, i_val[7:1]};
  wire [7:0] rol_res = {i_val[6:0], i_carry};
  wire [7:0] ror_res = {i_carry, i_val[7:1]};
  wire [7:0] asr_res = {i_val[7], i_val[7:1]};

  assign o_res = (i_op == OP_LSL) ? lsl_res :
                 (i_op == OP_LSR) ? lsr_res :
                 (i_op == OP_ROL) ? rol_res :
                 (i_op == OP_ROR) ? ror_res : asr_res;

  // carry from the bit shifted out
  assign o_c = left_sel ? i_val[7] : i_val[0];
  assign o_n = o_res[7];
  assign o_z = (o_res == 8'h00);
  assign o_v = o_n ^ o_c;

endmodule : bsme_shift_unit
